/* File: rtl/hie_exec.sv */
// execute unit for sleep, increment, branch, copy, union, return and rotate ops
module hie_exec
  import hie_pkg::*;
(
  input  wire logic              mclk,               // 50 MHz core clock
  input  wire logic              rstn,               // asynchronous reset, active low
  input  wire hie_instr_t        instr,              // decoded instruction
  input  wire logic              instr_valid,        // instruction offered
  output logic                   instr_ready,        // instruction can be taken this edge
  input  wire logic              wake_pin,           // wake-up request from a pin
  input  wire logic              stack_push,         // push from the call logic
  input  wire logic [PC_W-1:0]   stack_push_pc,      // return address to push
  input  wire logic              watchdog_timeout,   // watchdog expiry pulse
  input  wire logic              icr_we,             // software write to control register
  input  wire logic [DATA_W-1:0] icr_wdata,          // value written to control register
  input  wire logic [ADDR_W-1:0] mem_peek_addr,      // observation read address
  output logic [DATA_W-1:0]      mem_peek_data,      // observation read data
  output logic [DATA_W-1:0]      acc,                // accumulator
  output logic [PC_W-1:0]        pc,                 // program counter
  output hie_flags_t             flags,              // status flags
  output logic [DATA_W-1:0]      interrupt_control_register, // interrupt control
  output logic                   global_interrupt_enable,    // master interrupt enable
  output logic                   halted,             // execution stopped
  output logic                   sys_clk_run,        // system clock enable
  output logic                   watchdog_clear,     // clears watchdog_counter and prescaler
  output logic                   instr_done          // one instruction finished
);

  // two-cycle ops park here for their second machine cycle
  typedef enum logic [0:0] {
    ST_RUN,
    ST_SECOND
  } hie_state_t;

  // byte operator shared by every data-path op
  function automatic hie_alu_t hie_alu(input hie_op_t op, input logic [DATA_W-1:0] m,
                                       input logic [DATA_W-1:0] a,
                                       input logic [DATA_W-1:0] k, input logic c);
    hie_alu_t r;
    r.value = m;
    r.carry = c;
    case (op)
      incr_mem_op, add_one_to_accumulator_op: begin
        r.value = m + BYTE_ONE;
      end
      copy_imm_to_acc_op, exit_with_constant_op: begin
        r.value = k;
      end
      copy_acc_to_mem_op: begin
        r.value = a;
      end
      union_mem_to_acc_op, bitwise_union_to_memory_op: begin
        r.value = a | m;
      end
      union_imm_to_acc_op: begin
        r.value = a | k;
      end
      rotate_left_op, rotate_left_to_acc_op: begin
        r.value = {m[MSB_POS-1:LSB_POS], m[MSB_POS]};
      end
      rotate_left_via_carry_op, rotate_left_via_carry_to_acc_op: begin
        r.value = {m[MSB_POS-1:LSB_POS], c};
        r.carry = m[MSB_POS];
      end
      rotate_right_op, rotate_right_to_acc_op: begin
        r.value = {m[LSB_POS], m[MSB_POS:LSB_POS+1]};
      end
      rotate_right_via_carry_op, rotate_right_via_carry_to_acc_op: begin
        r.value = {c, m[MSB_POS:LSB_POS+1]};
        r.carry = m[LSB_POS];
      end
      default: begin
        r.value = m;
      end
    endcase
    return r;
  endfunction : hie_alu

  // reset release through two flip-flops
  logic rst_meta_q;
  logic rst_sync_q;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  wire rst_n = rst_sync_q;  // design-wide reset copy

  // wake pin synchroniser; only the second stage is read
  logic wake_meta_q;
  logic wake_sync_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wake_meta_q <= 1'b0;
      wake_sync_q <= 1'b0;
    end else begin
      wake_meta_q <= wake_pin;
      wake_sync_q <= wake_meta_q;
    end
  end

  // architectural state
  logic [DATA_W-1:0]   acc_q, acc_d;         // accumulator
  logic [PC_W-1:0]     pc_q, pc_d;           // program counter
  logic [SP_W-1:0]     sp_q, sp_d;           // stack fill pointer
  logic                carry_q, carry_d;     // carry flag
  logic                zero_q, zero_d;       // zero flag
  logic                pdf_q, pdf_d;         // power_down_flag
  logic                wef_q, wef_d;         // watchdog_expiry_flag
  logic [DATA_W-1:0]   icr_q, icr_d;         // interrupt_control_register
  logic                halt_q, halt_d;       // sleeping
  logic                wdc_q, wdc_d;         // watchdog clear pulse
  logic                done_q, done_d;       // completion pulse
  hie_state_t          state_q, state_d;     // machine cycle tracker
  hie_op_t             op2_q;                // op held over into second cycle
  logic [DATA_W-1:0]   imm2_q;               // constant held over
  logic [PC_W-1:0]     tgt2_q;               // branch target held over
  logic [PC_W-1:0]     stack_q [STACK_DEPTH];  // return stack
  logic [DATA_W-1:0]   mem_q   [MEM_DEPTH];    // data memory

  // acceptance and operand fetch
  wire               take    = instr_valid && instr_ready;
  wire hie_op_t      op      = instr.op;
  wire [DATA_W-1:0]  mem_rd  = mem_q[instr.addr];
  wire hie_alu_t     alu     = hie_alu(op, mem_rd, acc_q, instr.imm, carry_q);
  wire               alu_z   = (alu.value == '0);

  // op classes
  wire to_mem  = (op == incr_mem_op) || (op == copy_acc_to_mem_op) ||
                 (op == bitwise_union_to_memory_op) || (op == rotate_left_op) ||
                 (op == rotate_left_via_carry_op) || (op == rotate_right_op) ||
                 (op == rotate_right_via_carry_op);
  wire to_acc  = (op == add_one_to_accumulator_op) || (op == copy_mem_to_acc_op) ||
                 (op == copy_imm_to_acc_op) || (op == union_mem_to_acc_op) ||
                 (op == union_imm_to_acc_op) || (op == rotate_left_to_acc_op) ||
                 (op == rotate_left_via_carry_to_acc_op) ||
                 (op == rotate_right_to_acc_op) ||
                 (op == rotate_right_via_carry_to_acc_op);
  wire upd_z   = (op == incr_mem_op) || (op == add_one_to_accumulator_op) ||
                 (op == union_mem_to_acc_op) || (op == union_imm_to_acc_op) ||
                 (op == bitwise_union_to_memory_op);
  wire upd_c   = (op == rotate_left_via_carry_op) ||
                 (op == rotate_left_via_carry_to_acc_op) ||
                 (op == rotate_right_via_carry_op) ||
                 (op == rotate_right_via_carry_to_acc_op);
  wire two_cyc = (op == direct_branch_op) || (op == subroutine_exit_op) ||
                 (op == exit_with_constant_op) || (op == interrupt_exit_op);

  // memory write strobe from the first cycle
  wire mem_we = take && to_mem;

  // pop address: the newest entry sits below the fill pointer
  wire [SP_W-1:0] sp_top = sp_q - SP_ONE;
  wire [PC_W-1:0] pop_pc = stack_q[sp_top];

  // stalls while sleeping or finishing a two-cycle op
  assign instr_ready = (state_q == ST_RUN) && !halt_q;

  // next-state logic for every architectural register
  always_comb begin
    acc_d   = acc_q;
    pc_d    = pc_q;
    sp_d    = sp_q;
    carry_d = carry_q;
    zero_d  = zero_q;
    pdf_d   = pdf_q;
    wef_d   = wef_q;
    icr_d   = icr_q;
    halt_d  = halt_q;
    wdc_d   = 1'b0;
    done_d  = 1'b0;
    state_d = state_q;
    // software write to the control register comes first; ops override
    if (icr_we) begin
      icr_d = icr_wdata;
    end
    // wake only clears the sleep, a fresh sleep entry below wins
    if (wake_sync_q) begin
      halt_d = 1'b0;
    end
    // watchdog expiry sets its flag; sleep entry below clears it
    if (watchdog_timeout) begin
      wef_d = 1'b1;
    end
    // the call logic pushes a return address; pointer wraps like the core
    if (stack_push) begin
      sp_d = sp_q + SP_ONE;
    end
    case (state_q)
      ST_RUN: begin
        if (take) begin
          if (two_cyc) begin
            state_d = ST_SECOND;
          end else begin
            pc_d   = pc_q + PC_ONE;
            done_d = 1'b1;
          end
          if (to_acc) begin
            acc_d = alu.value;
          end
          if (upd_z) begin
            zero_d = alu_z;
          end
          if (upd_c) begin
            carry_d = alu.carry;
          end
          if (op == halt_op) begin
            halt_d = 1'b1;
            wdc_d  = 1'b1;
            pdf_d  = 1'b1;
            wef_d  = 1'b0;
          end
          if (two_cyc && (op != direct_branch_op) && !stack_push) begin
            sp_d = sp_top;
          end
        end
      end
      ST_SECOND: begin
        // the reload lands at the end of the second machine cycle
        state_d = ST_RUN;
        done_d  = 1'b1;
        case (op2_q)
          direct_branch_op: begin
            pc_d = tgt2_q;
          end
          exit_with_constant_op: begin
            pc_d  = stack_q[sp_q];
            acc_d = imm2_q;
          end
          interrupt_exit_op: begin
            pc_d         = stack_q[sp_q];
            icr_d[GIE_POS] = 1'b1;
          end
          default: begin
            pc_d = stack_q[sp_q];
          end
        endcase
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // architectural registers; flags move only where the op allows, except the watchdog expiry flag, which a watchdog_timeout also sets
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q   <= ACC_RST;
      pc_q    <= PC_RST;
      sp_q    <= SP_RST;
      carry_q <= FLAG_RST;
      zero_q  <= FLAG_RST;
      pdf_q   <= FLAG_RST;
      wef_q   <= FLAG_RST;
      icr_q   <= ICR_RST;
      halt_q  <= 1'b0;
      wdc_q   <= 1'b0;
      done_q  <= 1'b0;
      state_q <= ST_RUN;
    end else begin
      acc_q   <= acc_d;
      pc_q    <= pc_d;
      sp_q    <= sp_d;
      carry_q <= carry_d;
      zero_q  <= zero_d;
      pdf_q   <= pdf_d;
      wef_q   <= wef_d;
      icr_q   <= icr_d;
      halt_q  <= halt_d;
      wdc_q   <= wdc_d;
      done_q  <= done_d;
      state_q <= state_d;
    end
  end

  // hold the two-cycle op's operands; nothing else reads them
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      op2_q  <= idle_op;
      imm2_q <= ACC_RST;
      tgt2_q <= PC_RST;
    end else if (take && two_cyc) begin
      op2_q  <= op;
      imm2_q <= instr.imm;
      tgt2_q <= instr.target;
    end
  end

  // return stack entries, written only by a push
  for (genvar s = 0; s < STACK_DEPTH; s++) begin : g_stack
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        stack_q[s] <= PC_RST;
      end else if (stack_push && (sp_q == SP_W'(s))) begin
        stack_q[s] <= stack_push_pc;
      end
    end
  end

  // data memory bytes; only the to-memory ops write, sleep leaves all alone
  for (genvar b = 0; b < MEM_DEPTH; b++) begin : g_mem
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        mem_q[b] <= MEM_RST;
      end else if (mem_we && (instr.addr == ADDR_W'(b))) begin
        mem_q[b] <= alu.value;
      end
    end
  end

  // observation read of memory, registered so data leaves from flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mem_peek_data <= MEM_RST;
    end else begin
      mem_peek_data <= mem_q[mem_peek_addr];
    end
  end

  // outputs straight from state
  assign acc                        = acc_q;
  assign pc                         = pc_q;
  assign flags = '{watchdog_expiry_flag: wef_q,
                   power_down_flag:      pdf_q,
                   zero:                 zero_q,
                   carry:                carry_q};
  assign interrupt_control_register = icr_q;
  assign global_interrupt_enable    = icr_q[GIE_POS];
  assign halted                     = halt_q;
  assign sys_clk_run                = !halt_q;
  assign watchdog_clear             = wdc_q;
  assign instr_done                 = done_q;

endmodule : hie_exec

/* File: rtl/hie_pkg.sv */
// shared constants, opcodes and carrier types for the instruction execute slice
package hie_pkg;

  // data path geometry
  localparam int DATA_W      = 8;   // accumulator and memory byte width
  localparam int ADDR_W      = 6;   // data memory address width
  localparam int MEM_DEPTH   = 64;  // data memory bytes
  localparam int PC_W        = 10;  // program counter width
  localparam int STACK_DEPTH = 4;   // return stack levels
  localparam int SP_W        = 2;   // return stack pointer width

  // bit positions
  localparam int MSB_POS     = 7;   // top bit of a byte
  localparam int LSB_POS     = 0;   // bottom bit of a byte
  localparam int GIE_POS     = 0;   // global interrupt enable inside control register

  // reset values
  localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
  localparam logic [DATA_W-1:0] MEM_RST  = 8'h00;
  localparam logic [DATA_W-1:0] ICR_RST  = 8'h00;
  localparam logic [PC_W-1:0]   PC_RST   = 10'h000;
  localparam logic [SP_W-1:0]   SP_RST   = 2'h0;
  localparam logic              FLAG_RST = 1'b0;

  // increments used by counters and the incrementer
  localparam logic [DATA_W-1:0] BYTE_ONE = 8'h01;
  localparam logic [PC_W-1:0]   PC_ONE   = 10'h001;
  localparam logic [SP_W-1:0]   SP_ONE   = 2'h1;

  // instruction selector
  typedef enum logic [4:0] {
    halt_op, incr_mem_op, add_one_to_accumulator_op, direct_branch_op,
    copy_mem_to_acc_op, copy_imm_to_acc_op, copy_acc_to_mem_op, idle_op,
    union_mem_to_acc_op, union_imm_to_acc_op, bitwise_union_to_memory_op,
    subroutine_exit_op, exit_with_constant_op, interrupt_exit_op,
    rotate_left_op, rotate_left_to_acc_op, rotate_left_via_carry_op,
    rotate_left_via_carry_to_acc_op, rotate_right_op, rotate_right_to_acc_op,
    rotate_right_via_carry_op, rotate_right_via_carry_to_acc_op
  } hie_op_t;

  // one decoded instruction as handed over by the fetch stage
  typedef struct packed {
    hie_op_t             op;      // what to do
    logic [ADDR_W-1:0]   addr;    // data memory operand address
    logic [DATA_W-1:0]   imm;     // immediate constant
    logic [PC_W-1:0]     target;  // direct branch address
  } hie_instr_t;

  // status flags touched by this slice
  typedef struct packed {
    logic watchdog_expiry_flag;
    logic power_down_flag;
    logic zero;
    logic carry;
  } hie_flags_t;

  // result of the byte operator
  typedef struct packed {
    logic [DATA_W-1:0] value;     // computed byte
    logic              carry;     // carry out for the via-carry rotates
  } hie_alu_t;

endpackage : hie_pkg

/* File: verif/hie_exec_props.sv */
// concurrent checks on the ports of the instruction execute slice
module hie_exec_props
  import hie_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rstn,
  input wire hie_instr_t        instr,
  input wire logic              instr_valid,
  input wire logic              instr_ready,
  input wire logic              wake_pin,
  input wire logic [DATA_W-1:0] acc,
  input wire logic [PC_W-1:0]   pc,
  input wire hie_flags_t        flags,
  input wire logic [DATA_W-1:0] interrupt_control_register,
  input wire logic              global_interrupt_enable,
  input wire logic              halted,
  input wire logic              sys_clk_run,
  input wire logic              watchdog_clear,
  input wire logic              instr_done
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // an instruction is taken when offered and accepted on one edge
  wire logic take    = instr_valid && instr_ready;
  // ops that reload the program counter need a second cycle
  wire logic two_cyc = instr.op inside {direct_branch_op, subroutine_exit_op,
                                        exit_with_constant_op, interrupt_exit_op};

  sequence s_take(hie_op_t o);
    take && instr.op == o;
  endsequence
  // second cycle refuses, then the op completes
  sequence s_reload;
    !instr_ready ##1 instr_done;
  endsequence

  a_clock_mirror: assert property (
    sys_clk_run == !halted) else $error("clock enable disagrees with halt state");
  a_halted_refuse: assert property (
    halted |-> !instr_ready) else $error("instruction accepted while halted");
  a_halted_frozen: assert property (
    halted ##1 halted |-> $stable(pc) && $stable(acc)) else $error("state moved while halted");
  a_wake_bound: assert property (
    halted && wake_pin |-> ##[1:4] !halted) else $error("wake did not resume execution");
  a_halt_flags: assert property (
    s_take(halt_op) |=> halted && flags.power_down_flag && !flags.watchdog_expiry_flag
      && pc == $past(pc) + PC_ONE && flags.zero == $past(flags.zero)
      && flags.carry == $past(flags.carry)) else $error("sleep entry state wrong");
  a_halt_wd_clear: assert property (
    s_take(halt_op) |=> watchdog_clear ##1 !watchdog_clear) else $error("no watchdog clear");
  a_idle_step: assert property (
    s_take(idle_op) |=> pc == $past(pc) + PC_ONE && acc == $past(acc)
      && flags == $past(flags)) else $error("idle op changed state");
  a_imm_copy: assert property (
    s_take(copy_imm_to_acc_op) |=> acc == $past(instr.imm) && flags == $past(flags))
    else $error("immediate copy wrong");
  a_union_imm: assert property (
    s_take(union_imm_to_acc_op) |=> acc == ($past(acc) | $past(instr.imm))
      && flags.zero == (acc == 8'h00) && flags.carry == $past(flags.carry))
    else $error("immediate union wrong");
  a_branch_load: assert property (
    s_take(direct_branch_op) |=> s_reload ##0 pc == $past(instr.target, 2))
    else $error("branch target not loaded");
  a_sub_exit: assert property (
    s_take(subroutine_exit_op) |=> s_reload ##0 acc == $past(acc, 2)
      && flags == $past(flags, 2)) else $error("subroutine exit wrong");
  a_const_exit: assert property (
    s_take(exit_with_constant_op) |=> s_reload ##0 acc == $past(instr.imm, 2))
    else $error("exit constant not loaded");
  a_int_exit: assert property (
    s_take(interrupt_exit_op) |=> s_reload ##0 global_interrupt_enable)
    else $error("interrupt exit left enable low");
  a_gie_mirror: assert property (
    global_interrupt_enable == interrupt_control_register[GIE_POS])
    else $error("enable bit disagrees with control register");
  a_single_done: assert property (
    take && !two_cyc |=> instr_done) else $error("one cycle op did not finish");
endmodule : hie_exec_props

bind hie_exec hie_exec_props i_hie_exec_props (
  .mclk, .rstn, .instr, .instr_valid, .instr_ready, .wake_pin, .acc, .pc, .flags,
  .interrupt_control_register, .global_interrupt_enable, .halted, .sys_clk_run,
  .watchdog_clear, .instr_done
);

/* File: verif/test_mcu_instruction_exec_halt_to_rrc.sv */
// self-checking bench for the instruction execute slice
module test_mcu_instruction_exec_halt_to_rrc;
  timeunit 1ns;
  timeprecision 1ps;
  import hie_pkg::*;

  logic              mclk = 1'b0;
  logic              rstn = 1'b0;
  hie_instr_t        instr = '0;
  logic              instr_valid = 1'b0;
  logic              wake_pin = 1'b0;
  logic              stack_push = 1'b0;
  logic [PC_W-1:0]   stack_push_pc = '0;
  logic              watchdog_timeout = 1'b0;
  logic              icr_we = 1'b0;
  logic [DATA_W-1:0] icr_wdata = '0;
  logic [ADDR_W-1:0] mem_peek_addr = '0;
  logic [DATA_W-1:0] mem_peek_data, acc, interrupt_control_register;
  logic [PC_W-1:0]   pc;
  hie_flags_t        flags;
  logic instr_ready, global_interrupt_enable, halted, sys_clk_run, watchdog_clear, instr_done;
  int                miscompares = 0;
  int                check_count = 0;
  logic              wdc;  // watchdog clear seen during the last op

  hie_exec i_hie_exec (
    .mclk, .rstn, .instr, .instr_valid, .instr_ready, .wake_pin, .stack_push,
    .stack_push_pc, .watchdog_timeout, .icr_we, .icr_wdata, .mem_peek_addr,
    .mem_peek_data, .acc, .pc, .flags, .interrupt_control_register,
    .global_interrupt_enable, .halted, .sys_clk_run, .watchdog_clear, .instr_done
  );

  // 50 MHz clock
  always #10 mclk = ~mclk;

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  // offer one op, hold it until taken, then wait for its done pulse
  task automatic exec(input hie_op_t op, input logic [5:0] a, input logic [7:0] k,
                      input logic [9:0] t);
    int n;
    @(posedge mclk);
    instr       <= '{op, a, k, t};
    instr_valid <= 1'b1;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (instr_ready !== 1'b1 && n < 60);
    @(posedge mclk);
    instr_valid <= 1'b0;
    n = 0;
    wdc = 1'b0;
    do begin
      @(negedge mclk);
      wdc |= watchdog_clear;
      n++;
    end while (instr_done !== 1'b1 && n < 8);
    chk(10'(instr_done), 10'h001);
  endtask : exec

  // observe a memory byte through the one-cycle peek port
  task automatic mchk(input logic [5:0] a, input logic [7:0] exp);
    @(posedge mclk);
    mem_peek_addr <= a;
    @(posedge mclk);
    @(negedge mclk);
    chk(10'(mem_peek_data), 10'(exp));
  endtask : mchk

  // preload a byte by way of the accumulator, which keeps the value
  task automatic setm(input logic [5:0] a, input logic [7:0] v);
    exec(copy_imm_to_acc_op, 6'h00, v, 10'h000);
    exec(copy_acc_to_mem_op, a, 8'h00, 10'h000);
  endtask : setm

  task automatic push(input logic [9:0] p);
    @(posedge mclk);
    stack_push    <= 1'b1;
    stack_push_pc <= p;
    @(posedge mclk);
    stack_push    <= 1'b0;
  endtask : push

  task automatic t_moves;
    logic [9:0] p;
    setm(6'h05, 8'hA5);
    chk(10'(acc), 10'h0A5);
    mchk(6'h05, 8'hA5);
    exec(copy_imm_to_acc_op, 6'h00, 8'h00, 10'h000);
    exec(union_imm_to_acc_op, 6'h00, 8'h00, 10'h000);
    exec(copy_mem_to_acc_op, 6'h05, 8'h00, 10'h000);
    chk(10'(acc), 10'h0A5);
    chk(10'(flags.zero), 10'h001);
    p = pc;
    exec(idle_op, 6'h00, 8'h00, 10'h000);
    chk(pc, p + PC_ONE);
  endtask : t_moves

  task automatic t_inc;
    setm(6'h06, 8'hFF);
    exec(incr_mem_op, 6'h06, 8'h00, 10'h000);
    mchk(6'h06, 8'h00);
    chk(10'(flags.zero), 10'h001);
    exec(add_one_to_accumulator_op, 6'h06, 8'h00, 10'h000);
    chk(10'(acc), 10'h001);
    chk(10'(flags.zero), 10'h000);
    mchk(6'h06, 8'h00);
  endtask : t_inc

  task automatic t_or;
    setm(6'h09, 8'h30);
    exec(copy_imm_to_acc_op, 6'h00, 8'h03, 10'h000);
    exec(union_mem_to_acc_op, 6'h09, 8'h00, 10'h000);
    chk(10'(acc), 10'h033);
    exec(copy_imm_to_acc_op, 6'h00, 8'h00, 10'h000);
    exec(union_imm_to_acc_op, 6'h00, 8'h00, 10'h000);
    chk(10'(flags.zero), 10'h001);
    exec(union_imm_to_acc_op, 6'h00, 8'h48, 10'h000);
    chk(10'(acc), 10'h048);
    exec(bitwise_union_to_memory_op, 6'h09, 8'h00, 10'h000);
    mchk(6'h09, 8'h78);
    chk(10'(acc), 10'h048);
  endtask : t_or

  // all eight rotates; odd selector codes land in the accumulator
  task automatic t_rot;
    logic [7:0] v, e;
    logic       c, ci, cv;
    c = 1'b0;
    for (int i = 14; i <= 21; i++) begin
      v  = 8'h81 ^ 8'(i);
      cv = (i == 16) || (i == 17) || (i >= 20);
      ci = cv ? c : ((i < 18) ? v[7] : v[0]);
      e  = (i < 18) ? {v[6:0], ci} : {ci, v[7:1]};
      if (cv) begin
        c = (i < 18) ? v[7] : v[0];
      end
      setm(6'h07, v);
      exec(hie_op_t'(i), 6'h07, 8'h00, 10'h000);
      if (i % 2 == 1) begin
        chk(10'(acc), 10'(e));
        mchk(6'h07, v);
      end else begin
        mchk(6'h07, e);
      end
      chk(10'(flags.carry), 10'(c));
    end
  endtask : t_rot

  task automatic t_ret;
    push(10'h123);
    push(10'h2AB);
    exec(subroutine_exit_op, 6'h00, 8'h00, 10'h000);
    chk(pc, 10'h2AB);
    exec(exit_with_constant_op, 6'h00, 8'h3C, 10'h000);
    chk(pc, 10'h123);
    chk(10'(acc), 10'h03C);
    exec(direct_branch_op, 6'h00, 8'h00, 10'h3FF);
    chk(pc, 10'h3FF);
    @(posedge mclk);
    icr_we    <= 1'b1;
    icr_wdata <= 8'hF0;
    @(posedge mclk);
    icr_we    <= 1'b0;
    push(10'h055);
    chk(10'(interrupt_control_register), 10'h0F0);
    exec(interrupt_exit_op, 6'h00, 8'h00, 10'h000);
    chk(pc, 10'h055);
    chk(10'(interrupt_control_register), 10'h0F1);
  endtask : t_ret

  // expiry flag raised, then sleep; an offered op waits for the wake pin
  task automatic t_sleep;
    logic [9:0] p;
    @(posedge mclk);
    watchdog_timeout <= 1'b1;
    @(posedge mclk);
    watchdog_timeout <= 1'b0;
    @(negedge mclk);
    chk(10'(flags.watchdog_expiry_flag), 10'h001);
    p = pc;
    exec(halt_op, 6'h00, 8'h00, 10'h000);
    chk(10'(halted), 10'h001);
    chk(10'(sys_clk_run), 10'h000);
    chk(10'(flags.power_down_flag), 10'h001);
    chk(10'(flags.watchdog_expiry_flag), 10'h000);
    chk(pc, p + PC_ONE);
    chk(10'(wdc), 10'h001);
    fork
      exec(idle_op, 6'h00, 8'h00, 10'h000);
      begin
        repeat (6) @(negedge mclk);
        chk(pc, p + PC_ONE);
        chk(10'(instr_ready), 10'h000);
        @(posedge mclk);
        wake_pin <= 1'b1;
      end
    join
    @(posedge mclk);
    wake_pin <= 1'b0;
    chk(pc, p + 10'h002);
  endtask : t_sleep

  // main sequence: reset for 16 cycles, then each scenario in turn
  initial begin
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    t_moves();
    t_inc();
    t_or();
    t_rot();
    t_ret();
    t_sleep();
    wrap_up();
  end

  // the scenarios need well under 1000 cycles; allow five times that
  initial begin
    #100us;
    miscompares++;
    wrap_up();
  end
endmodule : test_mcu_instruction_exec_halt_to_rrc
